// ==== host_spi_model.sv ====
// Host controller model that runs serial command frames in mode 0, MSB first.
`timescale 1ns/10ps
module host_spi_model (
    input wire logic miso,
    output logic sck,
    output logic csn_n,
    output logic mosi
);
    // The serial clock stays low and select stays high between frames.
    initial
    begin
        sck = 1'b0;
        csn_n = 1'b1;
        mosi = 1'b0;
    end
    // Host sends only listed commands, clean bits and 1-byte payloads.
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        #32 csn_n = 1'b0;
        for (int i = 15; i >= 16 - 8 * n; i--)
        begin
            mosi = tx[i];
            #32 sck = 1'b1;
            rx[i] = miso;
            #32 sck = 1'b0;
        end
        #32 csn_n = 1'b1;
        // The released data line flips so a stale bit is never mistaken for data.
        mosi = ~mosi;
        #40;
    endtask : xfer
endmodule : host_spi_model

// ==== payload_fifo.sv ====
// Small first-in first-out queue with valid and ready on both sides.
`timescale 1ns/10ps
module payload_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW-1:0] DEPTH_CNT = AW'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] rd_reg, rd_next, wr_reg, wr_next, cnt_reg, cnt_next;
    logic push, pop;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == LAST) ? '0 : p + 1'b1;
    endfunction : wrap_inc

    // Flags follow the count at once, so a status read sees current occupancy.
    // live queue flags
    assign full = (cnt_reg == DEPTH_CNT);
    assign empty = (cnt_reg == '0);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer, count and storage updates; a flush empties the queue.
    always_comb
    begin
        mem_next = mem_reg;
        rd_next = rd_reg;
        wr_next = wr_reg;
        cnt_next = cnt_reg;
        if (flush)
        begin
            rd_next = '0;
            wr_next = '0;
            cnt_next = '0;
        end
        else
        begin
            if (push)
            begin
                mem_next[wr_reg] = in_data;
                wr_next = wrap_inc(wr_reg);
            end
            if (pop)
                rd_next = wrap_inc(rd_reg);
            cnt_next = cnt_reg + AW'(push) - AW'(pop);
        end
    end

    // State registers.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_reg[i] <= '0;
            rd_reg <= '0;
            wr_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            mem_reg <= mem_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            cnt_reg <= cnt_next;
        end
    end

    a_fifo_bound: assert property (@(posedge clk) disable iff (rst) cnt_reg <= DEPTH_CNT)
        else $error("queue holds more entries than its depth");
    a_flag_update: assert property (@(posedge clk) disable iff (rst)
        (push && !pop && !flush) |=> !empty)
        else $error("empty flag not cleared after a write");
endmodule : payload_fifo

// ==== payload_queue_and_option_ctrl.sv ====
// Payload queues, repeat-last-packet and option registers behind the serial command port.
// How it works
// - While repeat flag and chip-activate are high, the last packet is resent.
// - Repeat command sets the flag; send write or send discard clears it.
// - Status bit 5 shows send queue full, bit 4 shows it empty.
// - Status bit 1 shows receive queue full, bit 0 empty, resetting to 1.
// - Reply payloads, written with a pipe number, serve only receive operation.
// - At most three reply payloads wait at once over all pipes.
// - Reply payloads for one pipe leave in the order written.
// - Send payloads of 1 to 32 bytes go into a three-entry queue.
// - Received payloads from all pipes share one three-entry queue read by host.
// - Per-pipe variable length counts only with global enable and auto-reply set.
// - Option bit 2 enables variable payload length, reset 0.
// - Option bit 1 lets payloads ride on replies, reset 0.
// - Option bit 0 enables the no-reply send write, reset 0.
// - Fixed-length pipes use their static width; width 0 marks unused pipe.
`timescale 1ns/10ps
`include "pq_defs.svh"
module payload_queue_and_option_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic csn_n,
    input wire logic mosi,
    input wire logic ce,
    output logic miso,
    output logic miso_oe,
    output pq_pkg::payload_t send_pkt,
    output logic send_valid,
    input wire logic send_ready,
    input wire pq_pkg::payload_t recv_pkt,
    input wire logic recv_valid,
    output logic recv_ready,
    output pq_pkg::payload_t reply_pkt,
    output logic reply_valid,
    input wire logic reply_ready,
    input wire logic [5:0] pipe_auto_reply_en,
    input wire logic [5:0][5:0] pipe_static_width,
    output logic [5:0] pipe_varlen_active
);
    import pq_pkg::*;

    localparam int PW = $bits(payload_t);

    pins_t s1_reg, s2_reg, prev_reg;
    cmd_state_t cmd_reg, cmd_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next, out_reg, out_next;
    logic [5:0] idx_reg, idx_next;
    logic [4:0] addr_reg, addr_next;
    logic [2:0] pipe_reg, pipe_next;
    logic [255:0] asm_reg, asm_next;
    logic [5:0] varlen_reg, varlen_next;
    logic [2:0] opt_reg, opt_next;
    logic repeat_reg, repeat_next, have_last_reg, have_last_next;
    payload_t last_reg, last_next;
    logic sck_rise, sck_fall, frame_start, frame_end, byte_done;
    logic [7:0] byte_in, qstate;
    logic tx_push, tx_flush, tx_pop, tx_out_valid, tx_full, tx_empty;
    logic rx_push, rx_flush, rx_pop, rx_out_valid, rx_full, rx_empty;
    logic rp_push, rp_pop, rp_out_valid;
    payload_t tx_in, tx_out, rx_in, rx_out, rp_out, rp_in;
    logic [5:0] rx_width;

    // Byte of a payload, zero past its length or when nothing is queued.
    function automatic logic [7:0] payload_byte(input payload_t p, input logic ok,
                                                input logic [5:0] i);
        payload_byte = (ok && i < p.len) ? p.data[{i[4:0], 3'h0} +: 8] : 8'h00;
    endfunction : payload_byte

    // Read value of a register address; reserved bits and other addresses read zero.
    function automatic logic [7:0] reg_value(input logic [4:0] a, input logic [7:0] qs,
                                             input logic [5:0] vl, input logic [2:0] op);
        case (a)
            `QSTATE_ADDR: reg_value = qs;
            `VARLEN_ADDR: reg_value = {2'h0, vl};
            `OPT_ADDR: reg_value = {5'h00, op};
            default: reg_value = 8'h00;
        endcase
    endfunction : reg_value

    // Command byte decode.
    function automatic cmd_state_t decode_cmd(input logic [7:0] b);
        if (b[7:5] == `CMD_READ_REG_TOP)
            decode_cmd = CMD_READ_REG;
        else if (b[7:5] == `CMD_WRITE_REG_TOP)
            decode_cmd = CMD_WRITE_REG;
        else if (b == `CMD_WRITE_SEND)
            decode_cmd = CMD_WRITE_SEND;
        else if (b == `CMD_WRITE_SEND_NO_REPLY)
            decode_cmd = CMD_WRITE_NOREPLY;
        else if (b[7:3] == `CMD_WRITE_REPLY_TOP)
            decode_cmd = CMD_WRITE_REPLY;
        else if (b == `CMD_READ_RECV)
            decode_cmd = CMD_READ_RECV;
        else
            decode_cmd = CMD_DISCARD;
    endfunction : decode_cmd

    // Host pins pass two flip-flops; edges are found on the second stage only.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= '{sck: 1'b0, csn_n: 1'b1, mosi: 1'b0, ce: 1'b0};
            s2_reg <= '{sck: 1'b0, csn_n: 1'b1, mosi: 1'b0, ce: 1'b0};
            prev_reg <= '{sck: 1'b0, csn_n: 1'b1, mosi: 1'b0, ce: 1'b0};
        end
        else
        begin
            s1_reg <= '{sck: sck, csn_n: csn_n, mosi: mosi, ce: ce};
            s2_reg <= s1_reg;
            prev_reg <= s2_reg;
        end
    end

    assign sck_rise = s2_reg.sck && !prev_reg.sck && !s2_reg.csn_n;
    assign sck_fall = !s2_reg.sck && prev_reg.sck && !s2_reg.csn_n;
    assign frame_start = prev_reg.csn_n && !s2_reg.csn_n;
    assign frame_end = !prev_reg.csn_n && s2_reg.csn_n;
    assign byte_in = {shift_reg[6:0], s2_reg.mosi};
    assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);
    assign miso = out_reg[7];
    assign miso_oe = !s2_reg.csn_n;

    // Status register image built from live queue flags.
    // send, receive and repeat flags
    always_comb
    begin
        qstate = 8'h00;
        qstate[`QS_REPEAT] = repeat_reg;
        qstate[`QS_TX_FULL] = tx_full;
        qstate[`QS_TX_EMPTY] = tx_empty;
        qstate[`QS_RX_FULL] = rx_full;
        qstate[`QS_RX_EMPTY] = rx_empty;
    end

    // Serial command engine: shifting, decode, register writes and queue commits.
    always_comb
    begin
        cmd_next = cmd_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        out_next = out_reg;
        idx_next = idx_reg;
        addr_next = addr_reg;
        pipe_next = pipe_reg;
        asm_next = asm_reg;
        varlen_next = varlen_reg;
        opt_next = opt_reg;
        repeat_next = repeat_reg;
        tx_push = 1'b0;
        tx_flush = 1'b0;
        rx_flush = 1'b0;
        rx_pop = 1'b0;
        rp_push = 1'b0;
        if (frame_start)
        begin
            cmd_next = CMD_IDLE;
            bit_cnt_next = 3'h0;
            idx_next = 6'h00;
            asm_next = '0;
            out_next = qstate;
        end
        if (sck_rise)
        begin
            shift_next = byte_in;
            bit_cnt_next = bit_cnt_reg + 3'h1;
        end
        // Out byte keeps its MSB across the falling edge that closes a byte.
        if (sck_fall && bit_cnt_reg != 3'h0)
            out_next = {out_reg[6:0], 1'b0};
        if (byte_done && cmd_reg == CMD_IDLE)
        begin
            cmd_next = decode_cmd(byte_in);
            addr_next = byte_in[4:0];
            pipe_next = byte_in[2:0];
            out_next = 8'h00;
            if (decode_cmd(byte_in) == CMD_READ_REG)
                out_next = reg_value(byte_in[4:0], qstate, varlen_reg, opt_reg);
            if (decode_cmd(byte_in) == CMD_READ_RECV)
                out_next = payload_byte(rx_out, rx_out_valid, 6'h00);
            if (byte_in == `CMD_REPEAT_LAST_PACKET)
                repeat_next = 1'b1;
            if (byte_in == `CMD_FLUSH_SEND)
            begin
                tx_flush = 1'b1;
                repeat_next = 1'b0;
            end
            if (byte_in == `CMD_FLUSH_RECV)
                rx_flush = 1'b1;
        end
        else if (byte_done)
        begin
            case (cmd_reg)
                CMD_WRITE_REG:
                begin
                    if (addr_reg == `VARLEN_ADDR)
                        varlen_next = byte_in[5:0];
                    if (addr_reg == `OPT_ADDR)
                        opt_next = byte_in[2:0];
                    cmd_next = CMD_DISCARD;
                end
                CMD_WRITE_SEND, CMD_WRITE_NOREPLY, CMD_WRITE_REPLY:
                begin
                    if (idx_reg < `PAYLOAD_BYTES)
                    begin
                        asm_next[{idx_reg[4:0], 3'h0} +: 8] = byte_in;
                        idx_next = idx_reg + 6'h01;
                    end
                end
                CMD_READ_RECV:
                begin
                    if (idx_reg < `PAYLOAD_BYTES)
                        idx_next = idx_reg + 6'h01;
                    out_next = payload_byte(rx_out, rx_out_valid, idx_reg + 6'h01);
                end
                CMD_READ_REG:
                    out_next = reg_value(addr_reg, qstate, varlen_reg, opt_reg);
                default:
                    out_next = 8'h00;
            endcase
        end
        if (frame_end)
        begin
            case (cmd_reg)
                CMD_WRITE_SEND:
                begin
                    tx_push = (idx_reg != 6'h00);
                    repeat_next = 1'b0;
                end
                CMD_WRITE_NOREPLY:
                    tx_push = (idx_reg != 6'h00) && opt_reg[`OPT_NOREPLY];
                CMD_WRITE_REPLY:
                    rp_push = (idx_reg != 6'h00) && (pipe_reg < `PIPE_COUNT);
                CMD_READ_RECV:
                    rx_pop = (idx_reg != 6'h00) && rx_out_valid;
                default:
                    rx_pop = 1'b0;
            endcase
            cmd_next = CMD_IDLE;
        end
    end

    // Serial engine and option registers.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_reg <= CMD_IDLE;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            out_reg <= 8'h00;
            idx_reg <= 6'h00;
            addr_reg <= 5'h00;
            pipe_reg <= 3'h0;
            asm_reg <= '0;
            varlen_reg <= `VARLEN_RESET;
            opt_reg <= `OPT_RESET;
            repeat_reg <= 1'b0;
        end
        else
        begin
            cmd_reg <= cmd_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            out_reg <= out_next;
            idx_reg <= idx_next;
            addr_reg <= addr_next;
            pipe_reg <= pipe_next;
            asm_reg <= asm_next;
            varlen_reg <= varlen_next;
            opt_reg <= opt_next;
            repeat_reg <= repeat_next;
        end
    end

    // Radio side: send source, effective widths and reply gating.
    assign tx_in = '{data: asm_reg, len: idx_reg, pipe_number_field: 3'h0,
                     noreply: (cmd_reg == CMD_WRITE_NOREPLY)};
    // Reply entries keep the pipe number given in their write command.
    assign rp_in = '{data: asm_reg, len: idx_reg, pipe_number_field: pipe_reg,
                     noreply: 1'b0};
    assign rx_in = '{data: recv_pkt.data, len: rx_width,
                     pipe_number_field: recv_pkt.pipe_number_field, noreply: 1'b0};
    assign send_valid = s2_reg.ce && (repeat_reg ? have_last_reg : tx_out_valid);
    assign send_pkt = repeat_reg ? last_reg : tx_out;
    assign tx_pop = send_valid && send_ready && !repeat_reg;
    assign pipe_varlen_active = varlen_reg & pipe_auto_reply_en & {6{opt_reg[`OPT_VARLEN]}};
    assign rx_width = (recv_pkt.pipe_number_field >= `PIPE_COUNT) ? 6'h00 :
                      pipe_varlen_active[recv_pkt.pipe_number_field] ? recv_pkt.len :
                      pipe_static_width[recv_pkt.pipe_number_field];
    assign rx_push = recv_valid && (rx_width != 6'h00);
    assign reply_valid = rp_out_valid && opt_reg[`OPT_REPLY_PAY];
    assign reply_pkt = rp_out;
    assign rp_pop = reply_valid && reply_ready;

    // Remember the packet most recently handed to the radio.
    always_comb
    begin
        last_next = last_reg;
        have_last_next = have_last_reg;
        if (tx_pop)
        begin
            last_next = tx_out;
            have_last_next = 1'b1;
        end
    end

    // Last-packet registers.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            last_reg <= '0;
            have_last_reg <= 1'b0;
        end
        else
        begin
            last_reg <= last_next;
            have_last_reg <= have_last_next;
        end
    end

    // Send, receive and reply queues, three entries each.
    // one ordered reply queue
    payload_fifo #(.WIDTH(PW), .DEPTH(`QUEUE_DEPTH)) send_q (.clk(clk), .rst(rst),
        .flush(tx_flush), .in_valid(tx_push), .in_ready(), .in_data(tx_in),
        .out_valid(tx_out_valid), .out_ready(tx_pop), .out_data(tx_out),
        .full(tx_full), .empty(tx_empty));
    payload_fifo #(.WIDTH(PW), .DEPTH(`QUEUE_DEPTH)) recv_q (.clk(clk), .rst(rst),
        .flush(rx_flush), .in_valid(rx_push), .in_ready(recv_ready), .in_data(rx_in),
        .out_valid(rx_out_valid), .out_ready(rx_pop), .out_data(rx_out),
        .full(rx_full), .empty(rx_empty));
    payload_fifo #(.WIDTH(PW), .DEPTH(`QUEUE_DEPTH)) reply_q (.clk(clk), .rst(rst),
        .flush(1'b0), .in_valid(rp_push), .in_ready(), .in_data(rp_in),
        .out_valid(rp_out_valid), .out_ready(rp_pop), .out_data(rp_out),
        .full(), .empty());

    a_repeat_set: assert property (@(posedge clk) disable iff (rst)
        byte_done && cmd_reg == CMD_IDLE && byte_in == `CMD_REPEAT_LAST_PACKET
        |=> repeat_reg)
        else $error("repeat flag not set by its command");
    a_repeat_clear: assert property (@(posedge clk) disable iff (rst)
        tx_flush |=> !repeat_reg)
        else $error("repeat flag survives a send discard");
    a_repeat_send: assert property (@(posedge clk) disable iff (rst)
        repeat_reg && have_last_reg && s2_reg.ce |-> send_valid && send_pkt == last_reg)
        else $error("last packet not offered while repeating");
    a_tx_full_flag: assert property (@(posedge clk) disable iff (rst)
        $rose(qstate[`QS_TX_FULL]) |-> $past(tx_push))
        else $error("send full flag rose without a write");
    a_rx_empty_flag: assert property (@(posedge clk) disable iff (rst)
        rx_push && !rx_flush |=> !qstate[`QS_RX_EMPTY])
        else $error("receive empty flag stuck after a store");
    a_noreply_gate: assert property (@(posedge clk) disable iff (rst)
        frame_end && cmd_reg == CMD_WRITE_NOREPLY && !opt_reg[`OPT_NOREPLY] |-> !tx_push)
        else $error("no-reply write accepted while disabled");
    a_reply_gate: assert property (@(posedge clk) disable iff (rst)
        reply_valid |-> opt_reg[`OPT_REPLY_PAY])
        else $error("reply payload offered while disabled");
    a_static_width: assert property (@(posedge clk) disable iff (rst)
        rx_push && !pipe_varlen_active[recv_pkt.pipe_number_field]
        |-> rx_in.len == pipe_static_width[recv_pkt.pipe_number_field])
        else $error("fixed pipe stored with wrong width");
    c_repeat_send: cover property (@(posedge clk) disable iff (rst)
        repeat_reg && send_valid && send_ready);
    c_send_full: cover property (@(posedge clk) disable iff (rst) tx_full);
    c_recv_drain: cover property (@(posedge clk) disable iff (rst) rx_pop);
endmodule : payload_queue_and_option_ctrl

// ==== pq_defs.svh ====
// Register offsets, field positions, reset values and command codes of the payload queues.
`ifndef PQ_DEFS_SVH
`define PQ_DEFS_SVH
`define QSTATE_ADDR 5'h17
`define VARLEN_ADDR 5'h1c
`define OPT_ADDR 5'h1d
`define QS_REPEAT 6
`define QS_TX_FULL 5
`define QS_TX_EMPTY 4
`define QS_RX_FULL 1
`define QS_RX_EMPTY 0
`define OPT_VARLEN 2
`define OPT_REPLY_PAY 1
`define OPT_NOREPLY 0
`define VARLEN_RESET 6'h00
`define OPT_RESET 3'h0
`define QUEUE_DEPTH 3
`define PAYLOAD_BYTES 6'h20
`define PIPE_COUNT 3'h6
`define CMD_READ_REG_TOP 3'h0
`define CMD_WRITE_REG_TOP 3'h1
`define CMD_READ_RECV 8'h61
`define CMD_WRITE_SEND 8'ha0
`define CMD_WRITE_REPLY_TOP 5'h15
`define CMD_WRITE_SEND_NO_REPLY 8'hb0
`define CMD_FLUSH_SEND 8'he1
`define CMD_FLUSH_RECV 8'he2
`define CMD_REPEAT_LAST_PACKET 8'he3
`endif

// ==== pq_pkg.sv ====
// Types shared by the payload queue controller and its testbench.
package pq_pkg;
    // One queued payload with its length, pipe and no-reply marking.
    typedef struct packed {
        logic [255:0] data;
        logic [5:0] len;
        logic [2:0] pipe_number_field;
        logic noreply;
    } payload_t;
    // Pins from the host side, sampled together.
    typedef struct packed {
        logic sck;
        logic csn_n;
        logic mosi;
        logic ce;
    } pins_t;
    // Command in progress within one select frame.
    typedef enum logic [2:0] {
        CMD_IDLE,
        CMD_READ_REG,
        CMD_WRITE_REG,
        CMD_WRITE_SEND,
        CMD_WRITE_NOREPLY,
        CMD_WRITE_REPLY,
        CMD_READ_RECV,
        CMD_DISCARD
    } cmd_state_t;
endpackage : pq_pkg

// ==== testbench.sv ====
// Self-checking bench for the payload queues and option registers.
`timescale 1ns/10ps
module testbench;
    import pq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sck, csn_n, mosi, miso, miso_oe;
    logic ce = 1'b0;
    payload_t send_pkt, recv_pkt, reply_pkt;
    logic send_valid, recv_ready, reply_valid, send_ready, recv_valid, reply_ready;
    logic [5:0] auto_en = 6'h00;
    logic [5:0][5:0] widths = '0;
    logic [5:0] varlen_act;
    logic [15:0] rx;
    int errors = 0;
    int checks_done = 0;
    // The clock runs at 200 MHz.
    always #2.5 clk = ~clk;
    host_spi_model u_host (.miso(miso), .sck(sck), .csn_n(csn_n), .mosi(mosi));
    payload_queue_and_option_ctrl u_dut (.clk(clk), .rst(rst), .sck(sck),
        .csn_n(csn_n), .mosi(mosi), .ce(ce), .miso(miso), .miso_oe(miso_oe),
        .send_pkt(send_pkt), .send_valid(send_valid), .send_ready(send_ready),
        .recv_pkt(recv_pkt), .recv_valid(recv_valid), .recv_ready(recv_ready),
        .reply_pkt(reply_pkt), .reply_valid(reply_valid), .reply_ready(reply_ready),
        .pipe_auto_reply_en(auto_en), .pipe_static_width(widths),
        .pipe_varlen_active(varlen_act));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic cmd(input logic [7:0] c, input logic [7:0] d, input int n);
        u_host.xfer({c, d}, n, rx);
        // Realign to just after a clock edge so later stimulus never races it.
        step(1);
    endtask : cmd
    // Reads the status byte shifted out during a no-operation command.
    task automatic stat(input logic [7:0] exp);
        cmd(8'hff, 8'h00, 1);
        chk(rx[15:8], exp);
    endtask : stat
    task automatic wait_send;
        for (int i = 0; i < 20 && send_valid !== 1'b1; i++)
            step(1);
        chk(send_valid, 1'b1);
    endtask : wait_send
    task automatic pulse_send;
        send_ready = 1'b1;
        step(1);
        send_ready = 1'b0;
    endtask : pulse_send
    task automatic t_reset;
        stat(8'h11);
        chk(miso_oe, 1'b0);
        cmd(8'h1d, 8'h00, 2);
        chk(rx[7:0], 8'h00);
        cmd(8'h1c, 8'h00, 2);
        chk(rx[7:0], 8'h00);
    endtask : t_reset
    // Fills the send queue past its depth, drains it, then repeats the last packet.
    task automatic t_send;
        for (int i = 0; i < 4; i++)
            cmd(8'ha0, 8'h10 + i, 2);
        stat(8'h21);
        ce = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            wait_send;
            chk(send_pkt.data[7:0], 8'h10 + i);
            chk(send_pkt.len, 6'h01);
            pulse_send;
        end
        chk(send_valid, 1'b0);
        cmd(8'he3, 8'h00, 1);
        stat(8'h51);
        pulse_send;
        wait_send;
        chk(send_pkt.data[7:0], 8'h12);
        cmd(8'ha0, 8'h33, 2);
        stat(8'h01);
        wait_send;
        chk(send_pkt.data[7:0], 8'h33);
        cmd(8'he3, 8'h00, 1);
        cmd(8'he1, 8'h00, 1);
        stat(8'h11);
        chk(send_valid, 1'b0);
    endtask : t_send
    task automatic t_noreply;
        cmd(8'hb0, 8'h44, 2);
        stat(8'h11);
        cmd(8'h3d, 8'h07, 2);
        cmd(8'h1d, 8'h00, 2);
        chk(rx[7:0], 8'h07);
        cmd(8'hb0, 8'h44, 2);
        wait_send;
        chk(send_pkt.noreply, 1'b1);
        pulse_send;
    endtask : t_noreply
    // Fills the shared receive queue, drains it and checks the length options.
    task automatic t_recv;
        widths[1] = 6'h04;
        recv_pkt.pipe_number_field = 3'h1;
        for (int i = 0; i < 3; i++)
        begin
            recv_pkt.data[7:0] = 8'h80 + i;
            recv_valid = 1'b1;
            step(1);
        end
        recv_valid = 1'b0;
        chk(recv_ready, 1'b0);
        stat(8'h12);
        for (int i = 0; i < 3; i++)
        begin
            cmd(8'h61, 8'h00, 2);
            chk(rx[7:0], 8'h80 + i);
        end
        recv_pkt.pipe_number_field = 3'h2;
        recv_valid = 1'b1;
        step(1);
        recv_valid = 1'b0;
        stat(8'h11);
        cmd(8'h3c, 8'h02, 2);
        chk(varlen_act, 6'h00);
        auto_en = 6'h02;
        step(4);
        chk(varlen_act, 6'h02);
        cmd(8'h3d, 8'h03, 2);
        chk(varlen_act, 6'h00);
    endtask : t_recv
    // Writes four replies for one pipe; only three wait, and leave in order.
    task automatic t_reply;
        for (int i = 0; i < 4; i++)
            cmd(8'ha9, 8'hc0 + i, 2);
        cmd(8'h3d, 8'h05, 2);
        chk(reply_valid, 1'b0);
        cmd(8'h3d, 8'h07, 2);
        for (int i = 0; i < 3; i++)
        begin
            chk(reply_valid, 1'b1);
            chk(reply_pkt.data[7:0], 8'hc0 + i);
            chk(reply_pkt.pipe_number_field, 3'h1);
            reply_ready = 1'b1;
            step(1);
            reply_ready = 1'b0;
        end
        chk(reply_valid, 1'b0);
    endtask : t_reply
    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // Main sequence: reset for two cycles, then each scenario in turn.
    initial
    begin
        recv_pkt = '0;
        recv_pkt.len = 6'h01;
        send_ready = 1'b0;
        recv_valid = 1'b0;
        reply_ready = 1'b0;
        step(2);
        rst = 1'b0;
        step(4);
        t_reset;
        t_send;
        t_noreply;
        t_recv;
        t_reply;
        tally_and_finish;
    end
    // Watchdog well beyond the roughly 32 us that the frames take.
    initial
    begin
        #200000;
        errors++;
        tally_and_finish;
    end
endmodule : testbench
